// ### rtl/nbbm_dev.sv
// Flash device end: factory marks, grown failures and status answers.
// Assumes the controller waits for each answer before its next request.
`timescale 1ns/1ps
`include "nbbm_map.svh"
module nbbm_dev
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Link
	nbbm_if.dev lnk,
	// Factory marking and fault injection
	input wire logic fac_we,
	input wire logic [12:0] fac_blk,
	input wire logic fail_arm,
	input wire logic [3:0] err_inject,
	// State
	output logic ready,
	output logic [8:0] bad_cnt
);
	typedef struct packed
	{
		logic init;
		logic rdy;
		logic [12:0] ptr;
		logic rsp;
		logic [7:0] data;
		logic [3:0] ecc;
		logic fail;
		logic [8:0] cnt;
	} nbbm_dev_state_type;

	nbbm_dev_state_type q, d;
	logic fmark [`NBBM_BLOCKS];
	logic grown [`NBBM_BLOCKS];
	logic fm_we, fm_val, gr_we, gr_val, fails;
	logic [12:0] fm_addr, gr_addr;

	// Init sweep, then one answer per request in the next cycle
	always_comb
	begin
		d = q;
		d.rsp = 1'b0;
		fm_we = 1'b0;
		fm_val = 1'b0;
		fm_addr = q.ptr;
		gr_we = 1'b0;
		gr_val = 1'b0;
		gr_addr = q.ptr;
		fails = 1'b0;
		if (q.init)
		begin
			fm_we = 1'b1;
			gr_we = 1'b1;
			d.ptr = q.ptr + 13'h0001;
			if (q.ptr == `NBBM_LAST_BLK)
			begin
				d.init = 1'b0;
				d.rdy = 1'b1; // Registered so ready leaves a flop directly
			end
		end
		else
		begin
			// Block zero never takes a mark, and a load needs the bad total below its cap
			// A link erase owns the mark write port, so a load then is dropped uncounted
			if (fac_we && fac_blk != 13'h0000 && !fmark[fac_blk]
				&& !(lnk.req && lnk.cmd == nbbm_pkg::NBBM_CMD_ERASE)
				&& q.cnt < 9'(`NBBM_MAX_BAD))
			begin
				fm_we = 1'b1;
				fm_val = 1'b1;
				fm_addr = fac_blk;
				d.cnt = q.cnt + 9'h001;
			end
			if (lnk.req)
			begin
				d.rsp = 1'b1;
				d.ecc = 4'h0;
				gr_addr = lnk.blk;
				// Grown failures are only injected while the cap has room
				fails = grown[lnk.blk] || (fail_arm && q.cnt < 9'(`NBBM_MAX_BAD));
				case (lnk.cmd)
					nbbm_pkg::NBBM_CMD_READ:
					begin
						d.ecc = err_inject;
						// Marked block shows non-ff in spare of page 0 or 1
						d.data = (fmark[lnk.blk] && lnk.page < `NBBM_MARK_PAGES) ?
							`NBBM_BAD_MARK : `NBBM_GOOD_MARK;
					end
					nbbm_pkg::NBBM_CMD_PROG, nbbm_pkg::NBBM_CMD_ERASE:
					begin
						d.fail = fails;
						d.data = fails ? (`NBBM_ST_READY | `NBBM_ST_FAIL) : `NBBM_ST_READY;
						if (fails && !grown[lnk.blk])
						begin
							gr_we = 1'b1;
							gr_val = 1'b1;
							d.cnt = d.cnt + 9'h001;
						end
						// Erase wipes the factory mark for good; fac load loses here
						if (lnk.cmd == nbbm_pkg::NBBM_CMD_ERASE)
						begin
							fm_we = 1'b1;
							fm_val = 1'b0;
							fm_addr = lnk.blk;
						end
					end
					default:
						d.data = q.fail ? (`NBBM_ST_READY | `NBBM_ST_FAIL) : `NBBM_ST_READY;
				endcase
			end
		end
	end

	// State register
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			q.init <= 1'b1;
			q.rdy <= 1'b0;
			q.ptr <= 13'h0000;
			q.rsp <= 1'b0;
			q.data <= 8'h00;
			q.ecc <= 4'h0;
			q.fail <= 1'b0;
			q.cnt <= 9'h000;
		end
		else
			q <= d;
	end

	// Mark and grown-failure arrays, cleared by the init sweep
	always_ff @(posedge sys_clk)
	begin
		if (fm_we)
			fmark[fm_addr] <= fm_val;
		if (gr_we)
			grown[gr_addr] <= gr_val;
	end

	assign lnk.rsp = q.rsp;
	assign lnk.rsp_data = q.data;
	assign lnk.rsp_ecc = q.ecc;
	assign ready = q.rdy;
	assign bad_cnt = q.cnt;
endmodule

// ### rtl/nbbm_host.sv
// Flash controller end: scan, status checks, replacement and page order.
// Assumes the device answers each request and is ready before scan_start.
`timescale 1ns/1ps
`include "nbbm_map.svh"
module nbbm_host
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Link
	nbbm_if.host lnk,
	// User requests
	input wire logic scan_start,
	input wire logic op_valid,
	input wire nbbm_pkg::nbbm_cmd_type op_kind,
	input wire logic [12:0] op_blk,
	input wire logic [5:0] op_page,
	// User results
	output logic busy,
	output logic done,
	output logic refused,
	output logic remapped,
	output logic ecc_fixed,
	output logic ecc_bad,
	output logic scan_done,
	output logic [13:0] bad_total
);
	typedef struct packed
	{
		nbbm_pkg::nbbm_hstate_type st;
		logic [12:0] lblk;
		logic [12:0] phys;
		logic [12:0] old;
		logic [5:0] page;
		logic [5:0] cpg;
		nbbm_pkg::nbbm_cmd_type kind;
		logic scan_pg;
		logic copy;
		logic replaced;
		logic scanned;
		logic [13:0] spare;
		logic req;
		nbbm_pkg::nbbm_cmd_type cmd;
		logic [12:0] rblk;
		logic [5:0] rpage;
		logic busy;
		logic done;
		logic refused;
		logic remapped;
		logic ecc_fixed;
		logic ecc_bad;
		logic scan_done;
		logic [13:0] bad_total;
	} nbbm_host_state_type;

	nbbm_host_state_type q, d;
	// Per-block tables: bad flag, remap, and programming progress
	logic bad_map [`NBBM_BLOCKS];
	logic rm_v [`NBBM_BLOCKS];
	logic [12:0] rm_to [`NBBM_BLOCKS];
	logic wr_any [`NBBM_BLOCKS];
	logic [6:0] next_pg [`NBBM_BLOCKS];
	logic [5:0] start_pg [`NBBM_BLOCKS];
	logic bm_we, bm_val, rm_we, rm_val, tb_we, tb_any;
	logic [12:0] bm_addr, rm_addr, rm_dst, tb_addr;
	logic [6:0] tb_next;
	logic [5:0] tb_start;
	logic [5:0] cpg_inc;

	assign cpg_inc = q.cpg + 6'h01;

	// Controller sequence
	always_comb
	begin
		d = q;
		d.req = 1'b0;
		d.done = 1'b0;
		d.refused = 1'b0;
		d.remapped = 1'b0;
		d.ecc_fixed = 1'b0;
		d.ecc_bad = 1'b0;
		d.scan_done = 1'b0;
		bm_we = 1'b0;
		bm_val = 1'b0;
		bm_addr = q.lblk;
		rm_we = 1'b0;
		rm_val = 1'b0;
		rm_addr = q.lblk;
		rm_dst = q.phys;
		tb_we = 1'b0;
		tb_any = 1'b0;
		tb_addr = q.lblk;
		tb_next = 7'h00;
		tb_start = q.page;
		case (q.st)
			nbbm_pkg::H_IDLE:
			begin
				d.replaced = 1'b0;
				if (scan_start)
				begin
					d.busy = 1'b1;
					d.lblk = 13'h0000;
					d.scan_pg = 1'b0;
					d.scanned = 1'b0;
					d.bad_total = 14'h0000;
					d.spare = `NBBM_SPARE_BASE;
					d.st = nbbm_pkg::H_SC_RQ;
				end
				else if (op_valid)
				begin
					// Nothing reaches the array before the mark scan has run
					if (!q.scanned || {1'b0, op_blk} >= `NBBM_SPARE_BASE
						|| op_kind == nbbm_pkg::NBBM_CMD_STATUS)
						d.refused = 1'b1;
					else if (op_kind == nbbm_pkg::NBBM_CMD_PROG && wr_any[op_blk]
						&& {1'b0, op_page} < next_pg[op_blk])
						d.refused = 1'b1;
					else
					begin
						d.busy = 1'b1;
						d.lblk = op_blk;
						d.page = op_page;
						d.kind = op_kind;
						d.phys = rm_v[op_blk] ? rm_to[op_blk] : op_blk;
						d.old = d.phys;
						// A flagged block never takes a program or erase
						if (bad_map[d.phys] && op_kind != nbbm_pkg::NBBM_CMD_READ)
							d.st = nbbm_pkg::H_FIND;
						else
							d.st = nbbm_pkg::H_OP_RQ;
					end
				end
			end
			nbbm_pkg::H_SC_RQ:
			begin
				d.req = 1'b1;
				d.cmd = nbbm_pkg::NBBM_CMD_READ;
				d.rblk = q.lblk;
				d.rpage = {5'h00, q.scan_pg};
				d.st = nbbm_pkg::H_SC_WT;
			end
			nbbm_pkg::H_SC_WT:
			begin
				if (lnk.rsp)
				begin
					// Page 0 good means page 1 must be checked as well
					if (lnk.rsp_data == `NBBM_GOOD_MARK && !q.scan_pg)
						d.scan_pg = 1'b1;
					else
					begin
						bm_we = 1'b1;
						bm_val = lnk.rsp_data != `NBBM_GOOD_MARK;
						rm_we = 1'b1;
						tb_we = 1'b1;
						if (bm_val)
							d.bad_total = q.bad_total + 14'h0001;
						d.scan_pg = 1'b0;
						d.lblk = q.lblk + 13'h0001;
					end
					d.st = nbbm_pkg::H_SC_RQ;
					if (q.lblk == `NBBM_LAST_BLK && !d.scan_pg)
					begin
						d.scanned = 1'b1;
						d.scan_done = 1'b1;
						d.busy = 1'b0;
						d.st = nbbm_pkg::H_IDLE;
					end
				end
			end
			nbbm_pkg::H_OP_RQ:
			begin
				d.req = 1'b1;
				d.cmd = q.kind;
				d.rblk = q.phys;
				d.rpage = q.page;
				d.st = nbbm_pkg::H_OP_WT;
			end
			nbbm_pkg::H_OP_WT:
			begin
				if (lnk.rsp)
				begin
					d.copy = 1'b0;
					if (q.kind == nbbm_pkg::NBBM_CMD_READ)
					begin
						// Up to four flipped bits are correctable, more are lost
						d.ecc_bad = lnk.rsp_ecc > `NBBM_ECC_LIMIT;
						d.ecc_fixed = lnk.rsp_ecc != 4'h0 && !d.ecc_bad;
						d.st = nbbm_pkg::H_DONE;
					end
					else
						d.st = nbbm_pkg::H_ST_RQ;
				end
			end
			nbbm_pkg::H_ST_RQ:
			begin
				d.req = 1'b1;
				d.cmd = nbbm_pkg::NBBM_CMD_STATUS;
				d.rblk = q.phys;
				d.st = nbbm_pkg::H_ST_WT;
			end
			nbbm_pkg::H_ST_WT:
			begin
				if (lnk.rsp)
				begin
					if (lnk.rsp_data[`NBBM_ST_FAIL_BIT])
					begin
						d.old = q.phys;
						d.st = nbbm_pkg::H_FIND;
					end
					else if (q.copy)
					begin
						d.cpg = cpg_inc;
						d.st = (cpg_inc == q.page) ? nbbm_pkg::H_OP_RQ : nbbm_pkg::H_CP_RD;
					end
					else
						d.st = nbbm_pkg::H_DONE;
				end
			end
			nbbm_pkg::H_FIND:
			begin
				d.replaced = 1'b1;
				// Spare pool walk, one block per cycle; empty pool gives up
				if (q.spare == `NBBM_SPARE_END)
				begin
					d.refused = 1'b1;
					d.busy = 1'b0;
					d.st = nbbm_pkg::H_IDLE;
				end
				else
				begin
					d.spare = q.spare + 14'h0001;
					if (!bad_map[q.spare[12:0]])
					begin
						d.phys = q.spare[12:0];
						rm_we = 1'b1;
						rm_val = 1'b1;
						rm_dst = q.spare[12:0];
						d.cpg = start_pg[q.lblk];
						if (q.kind == nbbm_pkg::NBBM_CMD_PROG && wr_any[q.lblk]
							&& start_pg[q.lblk] < q.page)
							d.st = nbbm_pkg::H_CP_RD;
						else
							d.st = nbbm_pkg::H_OP_RQ;
					end
				end
			end
			nbbm_pkg::H_CP_RD:
			begin
				d.req = 1'b1;
				d.cmd = nbbm_pkg::NBBM_CMD_READ;
				d.rblk = q.old;
				d.rpage = q.cpg;
				d.st = nbbm_pkg::H_CP_RDW;
			end
			nbbm_pkg::H_CP_RDW:
			begin
				if (lnk.rsp)
				begin
					d.ecc_bad = lnk.rsp_ecc > `NBBM_ECC_LIMIT;
					d.st = nbbm_pkg::H_CP_PG;
				end
			end
			nbbm_pkg::H_CP_PG:
			begin
				// Same page position in the replacement block
				d.req = 1'b1;
				d.cmd = nbbm_pkg::NBBM_CMD_PROG;
				d.rblk = q.phys;
				d.rpage = q.cpg;
				d.st = nbbm_pkg::H_CP_PGW;
			end
			nbbm_pkg::H_CP_PGW:
			begin
				if (lnk.rsp)
				begin
					d.copy = 1'b1;
					d.st = nbbm_pkg::H_ST_RQ;
				end
			end
			nbbm_pkg::H_DONE:
			begin
				d.done = 1'b1;
				d.busy = 1'b0;
				d.st = nbbm_pkg::H_IDLE;
				if (q.kind != nbbm_pkg::NBBM_CMD_READ)
				begin
					tb_we = 1'b1;
					tb_any = q.kind == nbbm_pkg::NBBM_CMD_PROG;
					tb_next = {1'b0, q.page} + 7'h01;
					tb_start = wr_any[q.lblk] ? start_pg[q.lblk] : q.page;
				end
				// Failed block enters the table only after page n is safe
				if (q.replaced && !bad_map[q.old])
				begin
					bm_we = 1'b1;
					bm_val = 1'b1;
					bm_addr = q.old;
					d.bad_total = q.bad_total + 14'h0001;
				end
				d.remapped = q.replaced;
			end
			default:
				d.st = nbbm_pkg::H_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			q <= '0;
		else
			q <= d;
	end

	// Block tables; the scan rewrites every entry so no reset is needed
	always_ff @(posedge sys_clk)
	begin
		if (bm_we)
			bad_map[bm_addr] <= bm_val;
		if (rm_we)
		begin
			rm_v[rm_addr] <= rm_val;
			rm_to[rm_addr] <= rm_dst;
		end
		if (tb_we)
		begin
			wr_any[tb_addr] <= tb_any;
			next_pg[tb_addr] <= tb_next;
			start_pg[tb_addr] <= tb_start;
		end
	end

	assign lnk.req = q.req;
	assign lnk.cmd = q.cmd;
	assign lnk.blk = q.rblk;
	assign lnk.page = q.rpage;
	assign busy = q.busy;
	assign done = q.done;
	assign refused = q.refused;
	assign remapped = q.remapped;
	assign ecc_fixed = q.ecc_fixed;
	assign ecc_bad = q.ecc_bad;
	assign scan_done = q.scan_done;
	assign bad_total = q.bad_total;
endmodule

// ### rtl/nbbm_if.sv
// Command link between the flash controller and the flash device.
// Assumes both ends run on the same sys_clk; one request, one answer.
`timescale 1ns/1ps
interface nbbm_if;
	logic req;
	nbbm_pkg::nbbm_cmd_type cmd;
	nbbm_pkg::nbbm_blk_type blk;
	nbbm_pkg::nbbm_page_type page;
	logic rsp;
	logic [7:0] rsp_data;
	logic [3:0] rsp_ecc;

	modport dev (input req, input cmd, input blk, input page,
		output rsp, output rsp_data, output rsp_ecc);
	modport host (output req, output cmd, output blk, output page,
		input rsp, input rsp_data, input rsp_ecc);
endinterface

// ### rtl/nbbm_map.svh
// Constants of the bad-block manager: array geometry, marks, status bits.
// Assumes one x8 device with 64 pages per block and an abstract command link.
`ifndef NBBM_MAP_SVH
`define NBBM_MAP_SVH

`define NBBM_BLOCKS 8192
`define NBBM_LAST_BLK 13'h1fff
`define NBBM_MIN_VALID 8032
`define NBBM_MAX_BAD (`NBBM_BLOCKS - `NBBM_MIN_VALID)
`define NBBM_SPARE_BASE 14'h1f60
`define NBBM_SPARE_END 14'h2000
`define NBBM_MARK_PAGES 6'h02
`define NBBM_GOOD_MARK 8'hff
`define NBBM_BAD_MARK 8'h00
`define NBBM_ST_READY 8'h40
`define NBBM_ST_FAIL 8'h01
`define NBBM_ST_FAIL_BIT 0
`define NBBM_ECC_LIMIT 4'h4

`endif

// ### rtl/nbbm_pkg.sv
// Types shared by both ends of the bad-block manager link.
// Assumes the constants of nbbm_map.svh for the matching widths.
package nbbm_pkg;
	typedef logic [12:0] nbbm_blk_type;
	typedef logic [5:0] nbbm_page_type;

	typedef enum logic [1:0]
	{
		NBBM_CMD_READ = 2'h0,
		NBBM_CMD_PROG = 2'h1,
		NBBM_CMD_ERASE = 2'h2,
		NBBM_CMD_STATUS = 2'h3
	} nbbm_cmd_type;

	typedef enum logic [3:0]
	{
		H_IDLE = 4'h0,
		H_SC_RQ = 4'h1,
		H_SC_WT = 4'h2,
		H_OP_RQ = 4'h3,
		H_OP_WT = 4'h4,
		H_ST_RQ = 4'h5,
		H_ST_WT = 4'h6,
		H_FIND = 4'h7,
		H_CP_RD = 4'h8,
		H_CP_RDW = 4'h9,
		H_CP_PG = 4'ha,
		H_CP_PGW = 4'hb,
		H_DONE = 4'hc
	} nbbm_hstate_type;
endpackage

// ### verif/nbbm_asserts.sv
// Link checker: answer timing, status follow-up, marks and page order.
// Assumes both ends share sys_clk; tb instantiates it beside the link.
`timescale 1ns/1ps
module nbbm_asserts
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Link requests
	input wire logic req,
	input wire nbbm_pkg::nbbm_cmd_type cmd,
	input wire nbbm_pkg::nbbm_blk_type blk,
	input wire nbbm_pkg::nbbm_page_type page,
	// Link answers
	input wire logic rsp,
	input wire logic [7:0] rsp_data,
	input wire logic [3:0] rsp_ecc
);
	logic have_q;
	logic [12:0] blk_q;
	logic [5:0] page_q;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!arst_n);

	// Last programmed page; only one block is tracked, so order is checked on runs
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			have_q <= 1'b0;
			blk_q <= 13'h0;
			page_q <= 6'h0;
		end
		else if (req && cmd == nbbm_pkg::NBBM_CMD_PROG)
		begin
			have_q <= 1'b1;
			blk_q <= blk;
			page_q <= page;
		end
		else if (req && cmd == nbbm_pkg::NBBM_CMD_ERASE && blk == blk_q)
			have_q <= 1'b0; // Erase restarts the order
	end

	// Answer and spacing on the link
	chk_answer_next: assert property (req |=> rsp && !req)
		else $error("request not answered next cycle");
	chk_answer_cause: assert property (rsp |-> $past(req))
		else $error("answer without request");
	chk_status_after_op: assert property (req && cmd inside {nbbm_pkg::NBBM_CMD_PROG,
		nbbm_pkg::NBBM_CMD_ERASE} |-> ##3 req && cmd == nbbm_pkg::NBBM_CMD_STATUS)
		else $error("no status read after program or erase");
	chk_status_ready: assert property (rsp && $past(cmd) != nbbm_pkg::NBBM_CMD_READ
		|-> rsp_data[6])
		else $error("status without ready bit");
	chk_ecc_quiet: assert property (rsp && $past(cmd) != nbbm_pkg::NBBM_CMD_READ
		|-> rsp_ecc == 4'h0)
		else $error("error count on a non-read answer");
	chk_mark_value: assert property (rsp && $past(cmd) == nbbm_pkg::NBBM_CMD_READ
		|-> rsp_data inside {8'hff, 8'h00})
		else $error("spare byte neither good nor marked");
	chk_block0_good: assert property (rsp && $past(cmd) == nbbm_pkg::NBBM_CMD_READ
		&& $past(blk) == 13'h0 |-> rsp_data == 8'hff)
		else $error("block zero reads as marked");
	chk_page_ascend: assert property (req && cmd == nbbm_pkg::NBBM_CMD_PROG && have_q
		&& blk == blk_q |-> page > page_q)
		else $error("page programmed out of order");
endmodule

// ### verif/tb.sv
// Bench: controller and device joined on one link, user sides driven here.
// Assumes one full scan fits the run; device sweep ends within 9000 cycles.
`timescale 1ns/1ps
module tb;
	localparam logic [4:0] DN = 5'h01;
	localparam logic [4:0] RF = 5'h02;
	localparam logic [4:0] RM = 5'h05;
	// Error counts on both sides of the correction limit
	localparam logic [3:0] ECC_CASE [5] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'hf};
	logic sys_clk, arst_n, fac_we, fail_arm, scan_start, op_valid;
	logic [12:0] fac_blk, op_blk;
	logic [3:0] err_inject, e_val;
	logic [5:0] op_page;
	nbbm_pkg::nbbm_cmd_type op_kind;
	logic ready, busy, done, refused, remapped, ecc_fixed, ecc_bad, scan_done;
	logic [8:0] bad_cnt;
	logic [13:0] bad_total;
	logic [31:0] rnd;
	logic [4:0] got;
	int err_count, check_count, i;
	int n_cmd[4];

	nbbm_if lnk();
	nbbm_dev nbbm_dev_inst(.sys_clk(sys_clk), .arst_n(arst_n), .lnk(lnk), .fac_we(fac_we),
		.fac_blk(fac_blk), .fail_arm(fail_arm), .err_inject(err_inject), .ready(ready),
		.bad_cnt(bad_cnt));
	nbbm_host nbbm_host_inst(.sys_clk(sys_clk), .arst_n(arst_n), .lnk(lnk),
		.scan_start(scan_start), .op_valid(op_valid), .op_kind(op_kind), .op_blk(op_blk),
		.op_page(op_page), .busy(busy), .done(done), .refused(refused), .remapped(remapped),
		.ecc_fixed(ecc_fixed), .ecc_bad(ecc_bad), .scan_done(scan_done), .bad_total(bad_total));
	nbbm_asserts nbbm_asserts_inst(.sys_clk(sys_clk), .arst_n(arst_n), .req(lnk.req),
		.cmd(lnk.cmd), .blk(lnk.blk), .page(lnk.page), .rsp(lnk.rsp), .rsp_data(lnk.rsp_data),
		.rsp_ecc(lnk.rsp_ecc));

	// Clock
	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// Link traffic per command; fault armed for the first program only
	always @(posedge sys_clk)
	begin
		if (lnk.req === 1'b1)
			n_cmd[lnk.cmd] <= n_cmd[lnk.cmd] + 1;
		if (lnk.req === 1'b1 && lnk.cmd == nbbm_pkg::NBBM_CMD_PROG)
			fail_arm <= 1'b0;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Expected pulses of a read: {ecc_bad, ecc_fixed, -, -, done}
	function automatic logic [4:0] ecc_exp(input logic [3:0] e);
		return {e > 4'h4, e != 4'h0 && e <= 4'h4, 3'h1};
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			err_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Bounded wait for a level or pulse, sampled where settled
	task automatic wait_for(ref logic sig, input int lim);
		int n;
		for (n = 0; n < lim && sig !== 1'b1; n++)
			@(negedge sys_clk);
		if (n == lim)
		begin
			err_count++;
			close_out();
		end
	endtask

	task automatic tend(input string s);
		$display("test %s finished, mismatches %0d", s, err_count);
	endtask

	task automatic mark(input logic [12:0] b);
		@(posedge sys_clk);
		fac_we <= 1'b1;
		fac_blk <= b;
	endtask

	task automatic mark_end();
		@(posedge sys_clk);
		fac_we <= 1'b0;
		repeat (2) @(negedge sys_clk);
	endtask

	// One user operation; collects every result pulse until done or refused
	task automatic op(input nbbm_pkg::nbbm_cmd_type k, input logic [12:0] b,
		input logic [5:0] p, input logic [4:0] exp);
		int n;
		@(posedge sys_clk);
		n_cmd = '{0, 0, 0, 0};
		op_valid <= 1'b1;
		op_kind <= k;
		op_blk <= b;
		op_page <= p;
		got = 5'h0;
		@(posedge sys_clk);
		op_valid <= 1'b0;
		for (n = 0; n < 3000 && !(got[0] || got[1]); n++)
		begin
			@(negedge sys_clk);
			got = got | {ecc_bad, ecc_fixed, remapped, refused, done};
		end
		if (n == 3000)
		begin
			err_count++;
			close_out();
		end
		@(posedge sys_clk);
		check(got, exp);
	endtask

	// Main sequence
	initial
	begin
		{arst_n, fac_we, fail_arm, scan_start, op_valid} = 5'h0;
		{fac_blk, op_blk, err_inject, op_page} = 36'h0;
		op_kind = nbbm_pkg::NBBM_CMD_READ;
		{err_count, check_count} = 0;
		n_cmd = '{0, 0, 0, 0};
		rnd = 32'hcaaa;
		repeat (20) @(posedge sys_clk);
		arst_n <= 1'b1;
		wait_for(ready, 9000);
		// Factory marks: zero and a duplicate must not count
		rnd = lfsr(lfsr(rnd));
		mark(13'h0);
		mark(13'h5);
		mark(13'h5);
		mark(13'h100 + {1'b0, rnd[11:0]});
		mark(13'h1200 + {5'h0, rnd[19:12]});
		mark_end();
		check(bad_cnt, 3);
		op(nbbm_pkg::NBBM_CMD_PROG, 13'h7, 6'h0, RF);
		tend("marks");
		// Full scan builds the table
		@(posedge sys_clk);
		scan_start <= 1'b1;
		@(posedge sys_clk);
		scan_start <= 1'b0;
		wait_for(scan_done, 70000);
		repeat (2) @(negedge sys_clk);
		check(bad_total, 3);
		check(busy, 1'b0);
		tend("scan");
		// Error counts around the correction limit, one drawn at random
		for (i = 0; i < 6; i++)
		begin
			rnd = lfsr(rnd);
			// Expectation taken from the value driven, not the pin before its update
			e_val = (i < 5) ? ECC_CASE[i] : rnd[3:0];
			@(posedge sys_clk);
			err_inject <= e_val;
			op(nbbm_pkg::NBBM_CMD_READ, 13'h40 + 13'(i), 6'h0, ecc_exp(e_val));
		end
		// Clean reads from here on, so copy reads raise no error pulse
		err_inject <= 4'h0;
		tend("ecc");
		// Page order from a non-zero start, gaps allowed
		op(nbbm_pkg::NBBM_CMD_PROG, 13'h14, 6'h3, DN);
		check(n_cmd[3], 1);
		op(nbbm_pkg::NBBM_CMD_PROG, 13'h14, 6'h3, RF);
		op(nbbm_pkg::NBBM_CMD_PROG, 13'h14, 6'h2, RF);
		op(nbbm_pkg::NBBM_CMD_PROG, 13'h14, 6'h9, DN);
		op(nbbm_pkg::NBBM_CMD_ERASE, 13'h14, 6'h0, DN);
		check(n_cmd[3], 1);
		op(nbbm_pkg::NBBM_CMD_PROG, 13'h14, 6'h0, DN);
		tend("order");
		// Program failure on page 2: copy pages 0 and 1, then write page 2
		op(nbbm_pkg::NBBM_CMD_PROG, 13'h1e, 6'h0, DN);
		op(nbbm_pkg::NBBM_CMD_PROG, 13'h1e, 6'h1, DN);
		@(posedge sys_clk);
		fail_arm <= 1'b1;
		op(nbbm_pkg::NBBM_CMD_PROG, 13'h1e, 6'h2, RM);
		check(n_cmd[0], 2);
		check(n_cmd[1], 4);
		check(n_cmd[3], 4);
		check(bad_total, 4);
		op(nbbm_pkg::NBBM_CMD_PROG, 13'h1e, 6'h2, RF);
		op(nbbm_pkg::NBBM_CMD_PROG, 13'h1e, 6'h3, DN);
		tend("replace");
		// Flagged block redirected; spare pool and status kind refused
		op(nbbm_pkg::NBBM_CMD_PROG, 13'h5, 6'h0, RM);
		op(nbbm_pkg::NBBM_CMD_PROG, 13'h1f60, 6'h0, RF);
		op(nbbm_pkg::NBBM_CMD_STATUS, 13'h7, 6'h0, RF);
		tend("redirect");
		// Bad count stops at the floor of valid blocks
		for (i = 0; i < 200; i++)
			mark(13'h40 + 13'(i * 37));
		mark_end();
		check(bad_cnt, 160);
		tend("cap");
		close_out();
	end
endmodule
